// File: rtl/timed_output_queue.sv
// timed four channel output block with entry queue and status area
`timescale 1ns/1ps
`default_nettype none

//  Contract
// - four independent output channels, each with its own level indicator
// - output area holds 5 entries (20 bytes) or 15 entries (60 bytes)
// - each entry is four consecutive bytes, entries packed back to back
// - queue keeps at most 31 entries whatever the area size
// - with a full queue further entries are rejected, queue untouched
// - accepted entry stores time, output state and sequence number together
// - four byte status area readable by the controller
// - status byte 0: last accepted number, bit 6 one, bit 7 zero
// - status byte 1: next number to execute, bits 6 and 7 one
// - queue state 00h right after an entry was stored
// - queue state 01h when no following entry or number mismatch
// - queue state 02h when the queue has no new entries
// - queue state 03h when the queue is full
// - entries after one with bit 6 set are ignored in that write
// - queue state ored with 80h while a terminating entry is queued
// - status byte 3 shows the current number of queued entries
// - fault indicator on overload, short or overheat; run off without bus
// - channel indicator lit while output is one, dark while zero
// - state byte bits 7..4 drive channels 0..3, bits 3..0 zero
// - 32 bit microsecond counter from power-on, wraps, low word used
// - entry state applied when the microsecond low word equals its time
module timed_output_queue #(
  parameter int CHANNELS = 4,
  parameter int DEPTH = timed_output_pkg::QUEUE_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // configuration: high selects the 60 byte area
  input wire logic area_large,
  // output area byte writes and end of area write
  input wire logic area_wr,
  input wire logic [timed_output_pkg::AREA_ADDR_W-1:0] area_addr,
  input wire logic [7:0] area_wdata,
  input wire logic area_commit,
  // status area reads
  input wire logic stat_rd,
  input wire logic [1:0] stat_addr,
  output logic [7:0] stat_rdata,
  // field pins
  input wire logic overload_pin,
  input wire logic short_pin,
  input wire logic overheat_pin,
  input wire logic bus_ok_pin,
  // outputs and indicators
  output logic [CHANNELS-1:0] chan_out,
  output logic [CHANNELS-1:0] chan_led,
  output logic module_fault_indicator,
  output logic run_led,
  // walk busy, area writes during it are still stored
  output logic walk_busy
);

  localparam int ITEM_W = CHANNELS + 7 + 16;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam int AREA_BYTES = timed_output_pkg::LARGE_ENTRIES * timed_output_pkg::ENTRY_BYTES;
  localparam int US_W = $clog2(timed_output_pkg::CYCLES_PER_US);
  localparam logic [US_W-1:0] US_LAST = US_W'(timed_output_pkg::CYCLES_PER_US - 1);

  typedef enum logic [0:0] {WALK_IDLE, WALK_RUN} walk_t;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;

  // two flops per pin before any logic looks at it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end else begin
      pin_meta_reg <= {bus_ok_pin, overheat_pin, short_pin, overload_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // fault and run indicators
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      module_fault_indicator <= 1'b0;
      run_led <= 1'b0;
    end else begin
      module_fault_indicator <= |pin_sync_reg[2:0];
      run_led <= pin_sync_reg[3];
    end
  end

  // ----------------------------------------
  // microsecond counter
  // ----------------------------------------
  logic [US_W-1:0] presc_reg;
  logic [31:0] us_reg;
  logic us_tick;

  assign us_tick = (presc_reg == US_LAST);

  // prescaler to one microsecond, then free running wrap counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_reg <= '0;
      us_reg <= 32'h00000000;
    end else begin
      presc_reg <= us_tick ? '0 : presc_reg + 1'b1;
      if (us_tick) begin
        us_reg <= us_reg + 32'h00000001;
      end
    end
  end

  // ----------------------------------------
  // output area shadow
  // ----------------------------------------
  logic [7:0] area_mem [0:AREA_BYTES-1];
  logic [3:0] n_entries;

  assign n_entries = area_large ? 4'(timed_output_pkg::LARGE_ENTRIES)
                                : 4'(timed_output_pkg::SMALL_ENTRIES);

  // byte writes inside the configured area only
  always_ff @(posedge clk) begin
    if (area_wr && (area_addr < {n_entries, 2'b00})) begin
      area_mem[area_addr] <= area_wdata;
    end
  end

  // byte address of one field of one entry
  function automatic logic [5:0] ent_addr(input logic [3:0] idx, input logic [1:0] ofs);
    ent_addr = {idx, ofs};
  endfunction

  // ----------------------------------------
  // area walk into the queue
  // ----------------------------------------
  walk_t walk_reg;
  logic [3:0] idx_reg;
  logic [5:0] last_seq_reg;
  logic [7:0] cur_state;
  logic [7:0] cur_seq;
  logic [15:0] cur_time;
  logic [5:0] exp_seq;
  logic seq_match;
  logic seq_repeat;
  logic last_idx;
  logic push_valid;
  logic push_ready;
  logic push_fire;
  logic [ITEM_W-1:0] push_item;

  assign cur_state = area_mem[ent_addr(idx_reg, timed_output_pkg::ENT_STATE_OFS)];
  assign cur_seq = area_mem[ent_addr(idx_reg, timed_output_pkg::ENT_SEQ_OFS)];
  assign cur_time = {area_mem[ent_addr(idx_reg, timed_output_pkg::ENT_TIME_HI_OFS)],
                     area_mem[ent_addr(idx_reg, timed_output_pkg::ENT_TIME_LO_OFS)]};
  assign exp_seq = last_seq_reg + 6'h01;
  assign seq_match = (cur_seq[5:0] == exp_seq) && !cur_seq[7];
  assign seq_repeat = (cur_seq[5:0] == last_seq_reg);
  assign last_idx = (idx_reg == n_entries - 4'h1);
  assign push_valid = (walk_reg == WALK_RUN) && seq_match;
  assign push_fire = push_valid && push_ready;
  // state nibble, six bit number with end mark, time
  assign push_item = {cur_state[7:timed_output_pkg::STATE_CH_LSB],
                      cur_seq[6:0], cur_time};
  assign walk_busy = (walk_reg == WALK_RUN);

  // one entry per cycle; stops on end mark, full queue or area end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      walk_reg <= WALK_IDLE;
      idx_reg <= 4'h0;
    end else begin
      unique case (walk_reg)
        WALK_IDLE: begin
          if (area_commit) begin
            walk_reg <= WALK_RUN;
            idx_reg <= 4'h0;
          end
        end
        WALK_RUN: begin
          if ((push_fire && cur_seq[timed_output_pkg::SEQ_TERM_BIT])
              || (push_valid && !push_ready) || last_idx) begin
            walk_reg <= WALK_IDLE;
          end else begin
            idx_reg <= idx_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // last accepted number follows every stored entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_seq_reg <= timed_output_pkg::LAST_SEQ_RST;
    end else if (push_fire) begin
      last_seq_reg <= cur_seq[5:0];
    end
  end

  // ----------------------------------------
  // queue and execution
  // ----------------------------------------
  logic head_valid;
  logic pop_fire;
  logic [ITEM_W-1:0] head_item;
  logic [CNT_W-1:0] fill;
  logic [15:0] head_time;
  logic [6:0] head_seq;
  logic [CHANNELS-1:0] head_state;

  entry_fifo #(
    .WIDTH(ITEM_W),
    .DEPTH(DEPTH),
    .CNT_W(CNT_W)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_item),
    .out_valid(head_valid),
    .out_ready(pop_fire),
    .out_data(head_item),
    .count(fill)
  );

  assign head_time = head_item[15:0];
  assign head_seq = head_item[22:16];
  assign head_state = head_item[ITEM_W-1:23];
  assign pop_fire = head_valid && (us_reg[15:0] == head_time);

  // state byte bit 7 drives channel 0, bit 4 channel 3
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          chan_out[ch] <= 1'b0;
          chan_led[ch] <= 1'b0;
        end else if (pop_fire) begin
          chan_out[ch] <= head_state[CHANNELS-1-ch];
          chan_led[ch] <= head_state[CHANNELS-1-ch];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // status area
  // ----------------------------------------
  logic [7:0] code_reg;
  logic [CNT_W-1:0] term_cnt_reg;
  logic [7:0] stat_byte [0:3];
  logic drain_empty;

  assign drain_empty = pop_fire && !push_fire && (fill == CNT_W'(1));

  // queue state code, walk events win over the drain event
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_reg <= timed_output_pkg::QS_EMPTY;
    end else if (push_valid && !push_ready) begin
      code_reg <= timed_output_pkg::QS_FULL;
    end else if (push_fire) begin
      code_reg <= timed_output_pkg::QS_OK;
    end else if (walk_reg == WALK_RUN && !seq_match && !seq_repeat) begin
      code_reg <= timed_output_pkg::QS_NO_NEXT;
    end else if (drain_empty) begin
      code_reg <= timed_output_pkg::QS_EMPTY;
    end
  end

  // number of queued entries that carry the end mark
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      term_cnt_reg <= '0;
    end else begin
      term_cnt_reg <= term_cnt_reg
                      + CNT_W'(push_fire && cur_seq[timed_output_pkg::SEQ_TERM_BIT])
                      - CNT_W'(pop_fire && head_seq[timed_output_pkg::SEQ_TERM_BIT]);
    end
  end

  assign stat_byte[0] = timed_output_pkg::LAST_FIX_BITS | {2'b00, last_seq_reg};
  assign stat_byte[1] = timed_output_pkg::NEXT_FIX_BITS
                        | {2'b00, head_valid ? head_seq[5:0] : exp_seq};
  assign stat_byte[2] = code_reg
                        | ((term_cnt_reg != '0) ? timed_output_pkg::QS_TERM_FLAG : 8'h00);
  assign stat_byte[3] = 8'(fill);

  // registered read of one status byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_rdata <= 8'h00;
    end else if (stat_rd) begin
      stat_rdata <= stat_byte[stat_addr];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_led_mirror: assert property (chan_led == chan_out)
    else $error("channel indicator differs from output");
  a_last_fixed: assert property (stat_rd && stat_addr == 2'h0 |=> stat_rdata[7:6] == 2'b01)
    else $error("last accepted byte fixed bits wrong");
  a_next_fixed: assert property (stat_rd && stat_addr == 2'h1 |=> stat_rdata[7:6] == 2'b11)
    else $error("next number byte fixed bits wrong");
  a_full_reject: assert property (push_valid && !push_ready && !pop_fire |=> $stable(fill))
    else $error("full queue changed on rejected entry");
  a_full_code: assert property (push_valid && !push_ready |=> code_reg == 8'h03)
    else $error("full queue not reported");
  a_accept_seq: assert property (push_fire |=> last_seq_reg == $past(cur_seq[5:0])
                                  && code_reg == 8'h00)
    else $error("accepted number or ok code not updated");
  a_term_stop: assert property (push_fire && cur_seq[6] |=> walk_reg == WALK_IDLE)
    else $error("walk continued after end mark");
  a_exec_apply: assert property (pop_fire |=> chan_out[0] == $past(head_state[3])
                                  && chan_out[3] == $past(head_state[0]))
    else $error("entry state not applied on its time");
  a_us_period: assert property (us_tick |=> !us_tick [*8])
    else $error("microsecond tick too frequent");
  a_term_flag: assert property (term_cnt_reg != '0 |-> stat_byte[2][7])
    else $error("end mark flag missing");
  a_count_max: assert property (fill <= CNT_W'(DEPTH))
    else $error("queue beyond depth");

  c_store: cover property (push_fire);
  c_full: cover property (push_valid && !push_ready);
  c_exec: cover property (pop_fire && term_cnt_reg != '0);

endmodule

`default_nettype wire

// File: rtl/timed_output_pkg.sv
// constants shared by the timed output queue and its bench
package timed_output_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int US_PERIOD_NS = 1000;
  localparam int CYCLES_PER_US = US_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------
  // output area layout
  // ----------------------------------------
  localparam int ENTRY_BYTES = 4;
  localparam int SMALL_ENTRIES = 5;
  localparam int LARGE_ENTRIES = 15;
  localparam int AREA_ADDR_W = 6;
  localparam logic [1:0] ENT_STATE_OFS = 2'h0;
  localparam logic [1:0] ENT_SEQ_OFS = 2'h1;
  localparam logic [1:0] ENT_TIME_LO_OFS = 2'h2;
  localparam logic [1:0] ENT_TIME_HI_OFS = 2'h3;
  localparam int STATE_CH_LSB = 4;
  localparam int SEQ_TERM_BIT = 6;

  // ----------------------------------------
  // queue and status area
  // ----------------------------------------
  localparam int QUEUE_DEPTH = 31;
  localparam logic [1:0] STAT_LAST_OFS = 2'h0;
  localparam logic [1:0] STAT_NEXT_OFS = 2'h1;
  localparam logic [1:0] STAT_STATE_OFS = 2'h2;
  localparam logic [1:0] STAT_COUNT_OFS = 2'h3;
  localparam logic [7:0] LAST_FIX_BITS = 8'h40;
  localparam logic [7:0] NEXT_FIX_BITS = 8'hC0;
  localparam logic [5:0] LAST_SEQ_RST = 6'h00;
  localparam logic [7:0] QS_OK = 8'h00;
  localparam logic [7:0] QS_NO_NEXT = 8'h01;
  localparam logic [7:0] QS_EMPTY = 8'h02;
  localparam logic [7:0] QS_FULL = 8'h03;
  localparam logic [7:0] QS_TERM_FLAG = 8'h80;

endpackage

// File: rtl/entry_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module entry_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // fill level
  output logic [CNT_W-1:0] count
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  // handshakes from the honest fill level
  assign in_ready = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];
  assign count = count_reg;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers with wrap at depth
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == LAST_PTR) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == LAST_PTR) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

  // fill level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + 1'b1;
    end else if (pop && !push) begin
      count_reg <= count_reg - 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: dv/area_ctl.sv
// controller model that writes the output area and reads the status area
`timescale 1ns/1ps
`default_nettype none

module area_ctl (
  // clock
  input wire logic clk,
  // output area writes
  output logic area_wr,
  output logic [5:0] area_addr,
  output logic [7:0] area_wdata,
  output logic area_commit,
  // status reads
  output logic stat_rd,
  output logic [1:0] stat_addr,
  input wire logic [7:0] stat_rdata,
  input wire logic walk_busy
);
  // idle bus at time zero
  initial begin
    area_wr = 1'b0;
    area_addr = 6'h00;
    area_wdata = 8'h00;
    area_commit = 1'b0;
    stat_rd = 1'b0;
    stat_addr = 2'h0;
  end

  // one byte strobe, released lines show inverted values, gap stalls
  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d, input int gap);
    @(posedge clk);
    #1;
    area_wr = 1'b1;
    area_addr = a;
    area_wdata = d;
    @(posedge clk);
    #1;
    area_wr = 1'b0;
    area_addr = ~a;
    area_wdata = ~d;
    repeat (gap) @(posedge clk);
  endtask

  // four bytes of one entry: state, number, time low, time high
  task automatic put_entry(input logic [3:0] s, input logic [7:0] st, input logic [7:0] sq,
                           input logic [15:0] tm, input int gap);
    wr_byte({s, 2'h0}, st, gap);
    wr_byte({s, 2'h1}, sq, gap);
    wr_byte({s, 2'h2}, tm[7:0], gap);
    wr_byte({s, 2'h3}, tm[15:8], gap);
  endtask

  // end of area write, then bounded wait for the walk
  task automatic commit(output logic ok);
    @(posedge clk);
    #1;
    area_commit = 1'b1;
    @(posedge clk);
    #1;
    area_commit = 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 100; i++) begin
      if (walk_busy === 1'b0) begin
        ok = 1'b1;
        break;
      end
      @(posedge clk);
      #1;
    end
  endtask

  // status byte read, data valid one cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    stat_rd = 1'b1;
    stat_addr = a;
    @(posedge clk);
    #1;
    stat_rd = 1'b0;
    stat_addr = ~a;
    d = stat_rdata;
  endtask
endmodule

`default_nettype wire

// File: dv/timed_output_queue_bench.sv
// self-checking bench for the timed output queue
`timescale 1ns/1ps
`default_nettype none

module timed_output_queue_bench;
  logic clk, arst_n, area_large, area_wr, area_commit, stat_rd, walk_busy, ok;
  logic overload_pin, short_pin, overheat_pin, bus_ok_pin, module_fault_indicator, run_led;
  logic [5:0] area_addr;
  logic [7:0] area_wdata, stat_rdata, s0, s1, last_s;
  logic [1:0] stat_addr;
  logic [3:0] chan_out, chan_led;
  logic [31:0] rs, r;
  int bad_count, compares, cyc, tm;

  // ----
  // design and controller model
  // ----
  timed_output_queue dut_u (.clk(clk), .arst_n(arst_n), .area_large(area_large),
    .area_wr(area_wr), .area_addr(area_addr), .area_wdata(area_wdata),
    .area_commit(area_commit), .stat_rd(stat_rd), .stat_addr(stat_addr),
    .stat_rdata(stat_rdata), .overload_pin(overload_pin), .short_pin(short_pin),
    .overheat_pin(overheat_pin), .bus_ok_pin(bus_ok_pin), .chan_out(chan_out),
    .chan_led(chan_led), .module_fault_indicator(module_fault_indicator),
    .run_led(run_led), .walk_busy(walk_busy));
  area_ctl ctl_u (.clk(clk), .area_wr(area_wr), .area_addr(area_addr),
    .area_wdata(area_wdata), .area_commit(area_commit), .stat_rd(stat_rd),
    .stat_addr(stat_addr), .stat_rdata(stat_rdata), .walk_busy(walk_busy));

  // clock and cycle count since reset release
  always #20 clk = ~clk;
  always @(posedge clk or negedge arst_n) cyc <= arst_n ? cyc + 1 : 0;

  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [3:0] chan_of(input logic [7:0] s);
    return {s[4], s[5], s[6], s[7]};
  endfunction
  function automatic logic [7:0] qs(input logic [7:0] c, input logic term);
    return term ? (c | timed_output_pkg::QS_TERM_FLAG) : c;
  endfunction
  task automatic finish_test();
    $display("counts: %0d compares, %0d bad", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic give_up(input string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
    finish_test();
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic stat(input logic [1:0] a, input logic [7:0] exp, input string m);
    logic [7:0] d;
    ctl_u.rd(a, d);
    chk(d, exp, m);
  endtask
  task automatic do_commit();
    ctl_u.commit(ok);
    if (ok !== 1'b1) give_up("walk never ended");
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    arst_n = 1'b1;
  endtask
  // bounded wait until the queue is empty, then check outputs
  task automatic drain(input logic [3:0] exp);
    logic [7:0] d;
    for (int i = 0; i <= 8000; i++) begin
      ctl_u.rd(2'h3, d);
      if (d === 8'h00) break;
      if (i == 8000) give_up("queue never drained");
    end
    chk({4'h0, chan_out}, {4'h0, exp}, "outputs");
    chk({4'h0, chan_led}, {4'h0, exp}, "leds");
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    clk = 1'b0;
    area_large = 1'b0;
    {overload_pin, short_pin, overheat_pin, bus_ok_pin} = 4'h1;
    rs = 32'h0000004F;
    bad_count = 0;
    compares = 0;
    do_reset();
    stat(2'h0, 8'h40, "last after reset");
    stat(2'h1, 8'hC1, "next after reset");
    stat(2'h2, timed_output_pkg::QS_EMPTY, "state after reset");
    stat(2'h3, 8'h00, "count after reset");
    $display("test reset done");
    // two entries, the second ends the write, the third must be ignored
    r = rnd();
    s0 = {r[7:5], 5'h00};
    s1 = {~s0[7:4], 4'h0};
    tm = cyc / timed_output_pkg::CYCLES_PER_US + 40;
    ctl_u.put_entry(4'h0, s0, 8'h01, tm[15:0], 0);
    ctl_u.put_entry(4'h1, s1, 8'h42, 16'(tm + 2), 1);
    ctl_u.put_entry(4'h2, 8'hF0, 8'h03, 16'(tm + 4), 0);
    do_commit();
    stat(2'h0, 8'h42, "last after end mark");
    stat(2'h1, 8'hC1, "next head");
    stat(2'h2, qs(timed_output_pkg::QS_OK, 1'b1), "stored with end mark");
    stat(2'h3, 8'h02, "count after end mark");
    drain(chan_of(s1));
    stat(2'h1, 8'hC3, "next when empty");
    stat(2'h2, timed_output_pkg::QS_EMPTY, "state when drained");
    $display("test end mark done");
    // slot 0 expected number marked not valid, others wrong, slot past the area ignored
    for (int i = 0; i < 6; i++)
      ctl_u.put_entry(4'(i), 8'h00, (i == 0) ? 8'h83 : (i < 5) ? 8'(20 + i) : 8'h43,
                      tm[15:0], 0);
    do_commit();
    stat(2'h2, timed_output_pkg::QS_NO_NEXT, "number mismatch");
    stat(2'h3, 8'h00, "count after mismatch");
    stat(2'h0, 8'h42, "last after mismatch");
    $display("test mismatch done");
    // random fault pins reach the indicators
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      {overload_pin, short_pin, overheat_pin, bus_ok_pin} = r[3:0];
      repeat (4) @(posedge clk);
      #1;
      chk({7'h0, module_fault_indicator}, {7'h0, |r[3:1]}, "fault led");
      chk({7'h0, run_led}, {7'h0, r[0]}, "run led");
    end
    {overload_pin, short_pin, overheat_pin, bus_ok_pin} = 4'h1;
    $display("test indicators done");
    // large area: fill to 31, one more refused, then two entries per microsecond
    area_large = 1'b1;
    do_reset();
    tm = cyc / timed_output_pkg::CYCLES_PER_US + 200;
    last_s = 8'h00;
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      if (i < 31) last_s = {r[7:4], 4'h0};
      ctl_u.put_entry(4'(i % 15), {r[7:4], 4'h0}, (i == 31) ? 8'h60 : 8'(i + 1),
                      16'(tm + i / 2), int'(r[8]));
      if (i % 15 == 14 || i == 31) do_commit();
    end
    stat(2'h2, timed_output_pkg::QS_FULL, "full");
    stat(2'h3, 8'h1F, "count when full");
    stat(2'h0, 8'h5F, "last when full");
    stat(2'h1, 8'hC1, "head when full");
    drain(chan_of(last_s));
    stat(2'h1, 8'hE0, "next after drain");
    stat(2'h2, timed_output_pkg::QS_EMPTY, "state after drain");
    $display("test full queue done");
    finish_test();
  end
endmodule

`default_nettype wire
